//--- logic/cfg_pkg.sv
// Constants, types and register map for the drive address and IP config block.
// Assumes a single 250 MHz clock and a plain strobe register port.
package cfg_pkg;
  // ==========================================
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_US = 4;
  localparam logic [11:0] SETTLE_CYC = 12'(SETTLE_US * CLK_MHZ);
  localparam longint WARN_S = 30;
  localparam logic [32:0] WARN_CYC = 33'(WARN_S * 64'(CLK_MHZ) * 64'd1000000);
  // ==========================================
  // Register offsets
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_ADDR = 8'h04;
  localparam logic [7:0] A_IP = 8'h08;
  localparam logic [7:0] A_MASK = 8'h0c;
  localparam logic [7:0] A_ACT_IP = 8'h10;
  localparam logic [7:0] A_TEMP = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_IRQ = 8'h1c;
  localparam logic [7:0] A_IRQ_MASK = 8'h20;
  localparam logic [7:0] A_LOAD = 8'h24;
  localparam logic [7:0] A_PWM = 8'h28;
  // Command bits
  localparam int CMD_ACTIVATE = 0;
  localparam int CMD_REBOOT = 1;
  localparam int CMD_LOAD_BASIC = 2;
  // ==========================================
  // Reset and fixed values
  localparam logic [31:0] SUBNET_BASE = 32'hc0a80000;
  localparam logic [31:0] MASK_C = 32'hffffff00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DIGIT_MAX = 8'h09;
  localparam logic [7:0] TEMP_DISC = 8'h64;
  localparam logic [7:0] TEMP_WARN = 8'h69;
  localparam logic [15:0] I2T_PCT = 16'h00c8;
  localparam logic [15:0] STILL_PCT = 16'h008c;
  localparam logic [15:0] PEAK_PCT = 16'h012c;
  localparam logic [15:0] PEAK_8K_PCT = 16'h00fa;
  localparam logic [15:0] STILL_RPM = 16'h003c;
  localparam logic [15:0] LOAD_FULL = 16'h2710;
  localparam logic [15:0] LOAD_RESERVE = 16'h1f40;
  localparam int IRQ_W = 4;
  // ==========================================
  // State
  typedef enum logic {ST_SETTLE, ST_RUN} phase_e;
  typedef struct packed {
    logic [3:0] h1;
    logic [3:0] h2;
    logic [3:0] l1;
    logic [3:0] l2;
    phase_e phase;
    logic [11:0] settle;
    logic [7:0] addr;
    logic [31:0] ip;
    logic [31:0] mask;
    logic [31:0] act_ip;
    logic manual;
    logic [32:0] warn_cnt;
    logic warn;
    logic disc;
    logic pwr_off;
    logic [15:0] load;
    logic limit;
    logic [15:0] cur_lim;
    logic sw8k;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
  } state_s;
endpackage

//--- logic/drive_address_ip_config.sv
// Drive address, engineering IP and protection supervisor.
// Assumes switch digits come from pins; temperature, torque and speed from logic on clk_sys_i.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps

// Notes on behaviour
// (R1) Digits 00 leave stored address untouched
// (R2) Digits 01..99 copied to address at boot
// (R3) Address is tens times ten plus units
// (R4) Addresses need no ascending order
// (R5) Auto IP is subnet base plus address
// (R6) Auto only with class C, host unwritten
// (R7) Manual when mask differs or host written
// (R8) Manual IP ignores address and switches
// (R9) New IP active on activate or reboot
// (R10) Manual sticks until basic parameters reload
// (R11) Amplifier temperature readable by software
// (R12) Above disconnect limit, power stage off
// (R13) Warning above threshold, power off later
// (R14) I2t limiting above twice standstill torque
// (R15) Limit at full load, flag reserve
// (R16) Tighter current limit at standstill speed
// (R17) 4 or 8 kHz, 8 kHz derates torque
// (R18) Digits latched once per boot
module drive_address_ip_config #(
  parameter logic [32:0] WARN_CYCLES = cfg_pkg::WARN_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [3:0] sw_tens_i,
  input wire logic [3:0] sw_units_i,
  input wire logic [7:0] temp_i,
  input wire logic [15:0] torque_i,
  input wire logic [15:0] speed_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic [7:0] drive_addr_o,
  output logic [31:0] active_ip_o,
  output logic pstage_off_o,
  output logic power_off_o,
  output logic temp_warn_o,
  output logic [15:0] current_limit_o,
  output logic sw_freq_8k_o
);

  cfg_pkg::state_s st;
  cfg_pkg::state_s next_st;

  logic [7:0] sw_val;
  logic sw_ok;
  logic wr_cmd;
  logic act;
  logic reboot;
  logic load_basic;
  logic still;
  logic [15:0] thr;
  logic over;

  localparam int IRQ_W_L = cfg_pkg::IRQ_W;

  logic [IRQ_W_L-1:0] ev;
  logic [IRQ_W_L-1:0] clr;

  // ==========================================
  // Decode of switches and commands
  always_comb
  begin
    sw_val = 8'({4'h0, st.h2} * 8'h0a) + {4'h0, st.l2}; // R3
    sw_ok = ({4'h0, st.h2} <= cfg_pkg::DIGIT_MAX) && ({4'h0, st.l2} <= cfg_pkg::DIGIT_MAX);
    wr_cmd = wr_i && (addr_i == cfg_pkg::A_CMD);
    act = wr_cmd && wdata_i[cfg_pkg::CMD_ACTIVATE];
    reboot = wr_cmd && wdata_i[cfg_pkg::CMD_REBOOT];
    load_basic = wr_cmd && wdata_i[cfg_pkg::CMD_LOAD_BASIC];
    still = speed_i < cfg_pkg::STILL_RPM;
    thr = still ? cfg_pkg::STILL_PCT : cfg_pkg::I2T_PCT; // R16
    over = torque_i > thr; // R14
    clr = (wr_i && (addr_i == cfg_pkg::A_IRQ)) ? wdata_i[IRQ_W_L-1:0] : '0;
  end

  // ==========================================
  // Next state
  always_comb
  begin
    next_st = st;
    ev = '0;
    // Two-flop switch synchronisers
    next_st.h1 = sw_tens_i;
    next_st.h2 = st.h1;
    next_st.l1 = sw_units_i;
    next_st.l2 = st.l1;
    // Boot sequencing
    case (st.phase)
      cfg_pkg::ST_SETTLE:
      begin
        if (st.settle == cfg_pkg::SETTLE_CYC)
        begin
          next_st.phase = cfg_pkg::ST_RUN; // R18
          if (sw_ok && (sw_val != 8'h00)) // R1 R4
          begin
            next_st.addr = sw_val; // R2
          end
        end
        else
        begin
          next_st.settle = st.settle + 12'h001;
        end
      end
      cfg_pkg::ST_RUN:
      begin
        if (reboot)
        begin
          next_st.phase = cfg_pkg::ST_SETTLE; // R9
          next_st.settle = 12'h000;
        end
      end
      default:
      begin
        next_st.phase = cfg_pkg::ST_SETTLE;
      end
    endcase
    // Parameter writes
    if (wr_i && (addr_i == cfg_pkg::A_ADDR))
    begin
      next_st.addr = wdata_i[7:0];
    end
    if (wr_i && (addr_i == cfg_pkg::A_IP))
    begin
      next_st.ip = wdata_i;
      next_st.manual = 1'b1; // R7
    end
    if (wr_i && (addr_i == cfg_pkg::A_MASK))
    begin
      next_st.mask = wdata_i;
    end
    if (wr_i && (addr_i == cfg_pkg::A_PWM))
    begin
      next_st.sw8k = wdata_i[0]; // R17
    end
    if (wr_i && (addr_i == cfg_pkg::A_IRQ_MASK))
    begin
      next_st.irq_mask = wdata_i[IRQ_W_L-1:0];
    end
    // Basic parameter load restores auto mode
    if (load_basic)
    begin
      next_st.ip = cfg_pkg::SUBNET_BASE; // R10
      next_st.mask = cfg_pkg::MASK_C;
      next_st.manual = 1'b0;
    end
    if (next_st.mask != cfg_pkg::MASK_C)
    begin
      next_st.manual = 1'b1; // R6 R7
    end
    // Active IP follows activate or end of boot
    if (act || ((st.phase == cfg_pkg::ST_SETTLE) && (next_st.phase == cfg_pkg::ST_RUN)))
    begin
      if (st.manual)
      begin
        next_st.act_ip = st.ip; // R8
      end
      else
      begin
        next_st.act_ip = {cfg_pkg::SUBNET_BASE[31:8], next_st.addr}; // R5
      end
    end
    // Temperature supervision
    next_st.disc = temp_i > cfg_pkg::TEMP_DISC; // R12
    next_st.warn = temp_i > cfg_pkg::TEMP_WARN; // R13
    if (next_st.warn)
    begin
      if (st.warn_cnt != WARN_CYCLES)
      begin
        next_st.warn_cnt = st.warn_cnt + 33'h000000001;
      end
    end
    else
    begin
      next_st.warn_cnt = '0;
    end
    if (st.warn && (st.warn_cnt == WARN_CYCLES))
    begin
      next_st.pwr_off = 1'b1; // R13
    end
    if (reboot)
    begin
      next_st.pwr_off = 1'b0;
    end
    // Thermal load integrator
    if (over && (st.load != cfg_pkg::LOAD_FULL))
    begin
      next_st.load = st.load + 16'h0001; // R14
    end
    else if (!over && (st.load != 16'h0000))
    begin
      next_st.load = st.load - 16'h0001;
    end
    next_st.limit = next_st.load == cfg_pkg::LOAD_FULL; // R15
    if (next_st.limit)
    begin
      next_st.cur_lim = thr; // R14 R16
    end
    else
    begin
      next_st.cur_lim = next_st.sw8k ? cfg_pkg::PEAK_8K_PCT : cfg_pkg::PEAK_PCT; // R17
    end
    // Events: warn, power off, limit, reserve used
    ev[0] = next_st.warn && !st.warn;
    ev[1] = next_st.pwr_off && !st.pwr_off;
    ev[2] = next_st.limit && !st.limit;
    ev[3] = (next_st.load >= cfg_pkg::LOAD_RESERVE) && (st.load < cfg_pkg::LOAD_RESERVE); // R15
    next_st.irq_st = (st.irq_st & ~clr) | ev;
    next_st.irq = |(next_st.irq_st & next_st.irq_mask);
    // Read data for the cycle after the strobe
    next_st.rdata = 32'h00000000;
    if (rd_i)
    begin
      case (addr_i)
        cfg_pkg::A_ADDR: next_st.rdata = {24'h000000, st.addr};
        cfg_pkg::A_IP: next_st.rdata = st.ip;
        cfg_pkg::A_MASK: next_st.rdata = st.mask;
        cfg_pkg::A_ACT_IP: next_st.rdata = st.act_ip;
        cfg_pkg::A_TEMP: next_st.rdata = {24'h000000, temp_i}; // R11
        cfg_pkg::A_STAT: next_st.rdata = {25'h0000000, st.phase == cfg_pkg::ST_RUN, st.sw8k, st.limit,
                                          st.pwr_off, st.warn, st.disc, st.manual};
        cfg_pkg::A_IRQ: next_st.rdata = {28'h0000000, st.irq_st};
        cfg_pkg::A_IRQ_MASK: next_st.rdata = {28'h0000000, st.irq_mask};
        cfg_pkg::A_LOAD: next_st.rdata = {16'h0000, st.load};
        cfg_pkg::A_PWM: next_st.rdata = {31'h00000000, st.sw8k};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      st <= '0;
      st.phase <= cfg_pkg::ST_SETTLE;
      st.addr <= cfg_pkg::ADDR_RST;
      st.ip <= cfg_pkg::SUBNET_BASE;
      st.mask <= cfg_pkg::MASK_C;
      st.act_ip <= cfg_pkg::SUBNET_BASE;
      st.cur_lim <= cfg_pkg::PEAK_PCT;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign rdata_o = st.rdata;
  assign irq_o = st.irq;
  assign drive_addr_o = st.addr;
  assign active_ip_o = st.act_ip;
  assign pstage_off_o = st.disc;
  assign power_off_o = st.pwr_off;
  assign temp_warn_o = st.warn;
  assign current_limit_o = st.cur_lim;
  assign sw_freq_8k_o = st.sw8k;

  // ==========================================
  // Assertions
  logic boot_end;
  assign boot_end = (st.phase == cfg_pkg::ST_SETTLE) && (st.settle == cfg_pkg::SETTLE_CYC);

  sequence s_boot_end;
    boot_end && !wr_i;
  endsequence

  sequence s_activate;
    act && !load_basic;
  endsequence

  property p_zero_keep;
    @(posedge clk_sys_i) disable iff (reset_i)
    s_boot_end ##0 (st.h2 == 4'h0 && st.l2 == 4'h0) |=> $stable(st.addr);
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("address changed for digits 00"); // R1

  property p_copy;
    @(posedge clk_sys_i) disable iff (reset_i)
    s_boot_end ##0 (st.h2 <= 4'h9 && st.l2 <= 4'h9 && (st.h2 | st.l2) != 4'h0)
      |=> st.addr == 8'($past(st.h2) * 8'h0a) + 8'($past(st.l2));
  endproperty
  a_copy: assert property (p_copy) else $error("switch value not copied"); // R2 R3

  property p_auto_ip;
    @(posedge clk_sys_i) disable iff (reset_i)
    s_activate ##0 !st.manual |=> active_ip_o == {cfg_pkg::SUBNET_BASE[31:8], drive_addr_o};
  endproperty
  a_auto_ip: assert property (p_auto_ip) else $error("auto IP wrong"); // R5 R6

  property p_mask_manual;
    @(posedge clk_sys_i) disable iff (reset_i)
    st.mask != cfg_pkg::MASK_C |-> st.manual;
  endproperty
  a_mask_manual: assert property (p_mask_manual) else $error("non class C mask not manual"); // R7

  property p_manual_ip;
    @(posedge clk_sys_i) disable iff (reset_i)
    s_activate ##0 st.manual |=> active_ip_o == $past(st.ip);
  endproperty
  a_manual_ip: assert property (p_manual_ip) else $error("manual IP not used"); // R8

  property p_ip_hold;
    @(posedge clk_sys_i) disable iff (reset_i)
    !act && !boot_end |=> $stable(active_ip_o);
  endproperty
  a_ip_hold: assert property (p_ip_hold) else $error("active IP changed without command"); // R9

  property p_sticky;
    @(posedge clk_sys_i) disable iff (reset_i)
    st.manual && !load_basic |=> st.manual;
  endproperty
  a_sticky: assert property (p_sticky) else $error("manual mode left early"); // R10

  property p_disc;
    @(posedge clk_sys_i) disable iff (reset_i)
    temp_i > cfg_pkg::TEMP_DISC |=> pstage_off_o;
  endproperty
  a_disc: assert property (p_disc) else $error("no disconnection above limit"); // R12

  property p_warn;
    @(posedge clk_sys_i) disable iff (reset_i)
    (temp_i > cfg_pkg::TEMP_WARN)[*2] |-> temp_warn_o ##1 (temp_warn_o || temp_i <= cfg_pkg::TEMP_WARN);
  endproperty
  a_warn: assert property (p_warn) else $error("warning not raised"); // R13

  property p_limit;
    @(posedge clk_sys_i) disable iff (reset_i)
    st.limit |-> current_limit_o <= cfg_pkg::I2T_PCT && st.load == cfg_pkg::LOAD_FULL;
  endproperty
  a_limit: assert property (p_limit) else $error("limit not applied at full load"); // R14 R15 R16

  property p_latch;
    @(posedge clk_sys_i) disable iff (reset_i)
    st.phase == cfg_pkg::ST_RUN && !wr_i && !reboot |=> $stable(drive_addr_o);
  endproperty
  a_latch: assert property (p_latch) else $error("address moved after boot"); // R18

endmodule

//--- tb/drive_env_model.sv
// Model of the rotary switches and drive sensors seen by the config block.
// Assumes the bench sets values through its tasks; outputs move after rising edges.
`timescale 1ns/10ps
module drive_env_model (
  input wire logic clk_sys_i,
  output logic [3:0] sw_tens_o,
  output logic [3:0] sw_units_o,
  output logic [7:0] temp_o,
  output logic [15:0] torque_o,
  output logic [15:0] speed_o
);
  // ==========================================
  // Power-on values: switches at factory 00, cool idle motor
  initial
  begin
    sw_tens_o = 4'h0;
    sw_units_o = 4'h0;
    temp_o = 8'h19;
    torque_o = 16'h0000;
    speed_o = 16'h0000;
  end

  // Rotary digits, 4 bits each, driven as given with no 0..9 check
  task automatic set_sw(input logic [3:0] h, input logic [3:0] l);
    @(posedge clk_sys_i);
    sw_tens_o <= h;
    sw_units_o <= l;
  endtask

  // Temperature in deg C, torque in %, speed in min^-1
  task automatic set_phy(input logic [7:0] t, input logic [15:0] q, input logic [15:0] s);
    @(posedge clk_sys_i);
    temp_o <= t;
    torque_o <= q;
    speed_o <= s;
  endtask
endmodule

//--- tb/drive_address_ip_config_tb.sv
// Self-checking bench for the drive address, IP and protection block.
// Assumes the strobe register port of the block and a short warning span.
`timescale 1ns/10ps
module drive_address_ip_config_tb;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] sw_h;
  logic [3:0] sw_l;
  logic [7:0] temp;
  logic [15:0] torque;
  logic [15:0] speed;
  logic [31:0] rdata_o;
  logic [31:0] active_ip_o;
  logic [7:0] drive_addr_o;
  logic [15:0] current_limit_o;
  logic irq_o;
  logic pstage_off_o;
  logic power_off_o;
  logic temp_warn_o;
  logic sw_freq_8k_o;
  logic [31:0] rv;
  int n_errors = 0;
  int cmp_count = 0;

  // ==========================================
  // Clock, partner and design
  always #2 clk_sys_i = ~clk_sys_i;

  drive_env_model env (.clk_sys_i(clk_sys_i), .sw_tens_o(sw_h), .sw_units_o(sw_l),
    .temp_o(temp), .torque_o(torque), .speed_o(speed));

  drive_address_ip_config #(.WARN_CYCLES(33'h000000032)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .sw_tens_i(sw_h), .sw_units_i(sw_l), .temp_i(temp), .torque_i(torque), .speed_i(speed),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .drive_addr_o(drive_addr_o), .active_ip_o(active_ip_o), .pstage_off_o(pstage_off_o),
    .power_off_o(power_off_o), .temp_warn_o(temp_warn_o), .current_limit_o(current_limit_o),
    .sw_freq_8k_o(sw_freq_8k_o));

  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // Reboot with given digits, then wait out the settle phase
  task automatic boot(input logic [3:0] h, input logic [3:0] l);
    env.set_sw(h, l);
    wr(cfg_pkg::A_CMD, 32'h2);
    cyc(1010);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial
  begin
    repeat (40000) @(posedge clk_sys_i);
    n_errors++;
    end_sim();
  end

  // ==========================================
  // Test sequence
  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    cyc(1);
    chk(active_ip_o, cfg_pkg::SUBNET_BASE);
    chk(32'(current_limit_o), 32'h12c);
    env.set_sw(4'h1, 4'h3);
    cyc(1010);
    chk(32'(drive_addr_o), 32'h0d);
    chk(active_ip_o, 32'hc0a8000d);
    env.set_sw(4'h4, 4'h4);
    cyc(20);
    chk(32'(drive_addr_o), 32'h0d);
    $display("test boot address done");
    wr(cfg_pkg::A_IP, 32'h0a000005);
    rd(cfg_pkg::A_STAT, rv);
    chk(rv & 32'h1, 32'h1);
    chk(active_ip_o, 32'hc0a8000d);
    wr(cfg_pkg::A_CMD, 32'h1);
    cyc(2);
    chk(active_ip_o, 32'h0a000005);
    boot(4'h2, 4'h7);
    chk(32'(drive_addr_o), 32'h1b);
    chk(active_ip_o, 32'h0a000005);
    wr(cfg_pkg::A_CMD, 32'h4);
    wr(cfg_pkg::A_CMD, 32'h1);
    cyc(2);
    chk(active_ip_o, 32'hc0a8001b);
    wr(cfg_pkg::A_MASK, 32'hffff0000);
    rd(cfg_pkg::A_STAT, rv);
    chk(rv & 32'h1, 32'h1);
    wr(cfg_pkg::A_CMD, 32'h4);
    rd(cfg_pkg::A_STAT, rv);
    chk(rv & 32'h1, 32'h0);
    $display("test ip mode done");
    wr(cfg_pkg::A_ADDR, 32'h2a);
    boot(4'h0, 4'h0);
    chk(32'(drive_addr_o), 32'h2a);
    chk(active_ip_o, 32'hc0a8002a);
    boot(4'h9, 4'h9);
    chk(32'(drive_addr_o), 32'h63);
    $display("test switch range done");
    wr(cfg_pkg::A_IRQ_MASK, 32'h1);
    env.set_phy(8'h65, 16'h0, 16'h0);
    cyc(3);
    chk(32'(pstage_off_o), 32'h1);
    chk(32'(temp_warn_o), 32'h0);
    rd(cfg_pkg::A_TEMP, rv);
    chk(rv, 32'h65);
    env.set_phy(8'h6a, 16'h0, 16'h0);
    cyc(3);
    chk(32'(temp_warn_o), 32'h1);
    chk(32'(irq_o), 32'h1);
    cyc(60);
    chk(32'(power_off_o), 32'h1);
    rd(cfg_pkg::A_IRQ, rv);
    chk(rv & 32'h3, 32'h3);
    wr(cfg_pkg::A_IRQ, 32'hf);
    cyc(2);
    chk(32'(irq_o), 32'h0);
    env.set_phy(8'h19, 16'h0, 16'h0);
    boot(4'h9, 4'h9);
    chk(32'(power_off_o), 32'h0);
    $display("test thermal done");
    env.set_phy(8'h19, 16'h00fa, 16'h0064);
    cyc(10010);
    chk(32'(current_limit_o), 32'hc8);
    rd(cfg_pkg::A_LOAD, rv);
    chk(rv, 32'h2710);
    rd(cfg_pkg::A_IRQ, rv);
    chk(rv & 32'hc, 32'hc);
    env.set_phy(8'h19, 16'h00fa, 16'h001e);
    cyc(3);
    chk(32'(current_limit_o), 32'h8c);
    env.set_phy(8'h19, 16'h0064, 16'h001e);
    cyc(5);
    chk(32'(current_limit_o), 32'h12c);
    wr(cfg_pkg::A_PWM, 32'h1);
    cyc(2);
    chk(32'(sw_freq_8k_o), 32'h1);
    chk(32'(current_limit_o), 32'hfa);
    rd(8'h80, rv);
    chk(rv, 32'h0);
    $display("test limits done");
    end_sim();
  end
endmodule
